// ==== uart_infrared_pkg.sv ====
// constants, field positions and carrier types of the serial controller
package uart_infrared_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] TXDATA_OFFSET = 8'h08;
  localparam logic [7:0] RXDATA_OFFSET = 8'h0C;
  localparam logic [7:0] RATE_OFFSET = 8'h10;

  // mode register fields
  localparam int MODE_EN = 15;
  localparam int MODE_IDLE_STOP = 13;
  localparam int MODE_IR = 12;
  localparam int MODE_RTS_MODE = 11;
  localparam int MODE_PIN_LO = 8;
  localparam int MODE_WAKE = 7;
  localparam int MODE_LOOP = 6;
  localparam int MODE_AUTO = 5;
  localparam int MODE_RX_INV = 4;
  localparam int MODE_HS = 3;
  localparam int MODE_FRAME_LO = 1;
  localparam int MODE_STOP = 0;

  // status and control register fields
  localparam int STA_TXI1 = 15;
  localparam int STA_TX_POL = 14;
  localparam int STA_TXI0 = 13;
  localparam int STA_BRK = 11;
  localparam int STA_TX_EN = 10;
  localparam int STA_FULL = 9;
  localparam int STA_EMPTY = 8;
  localparam int STA_RXI_LO = 6;
  localparam int STA_ADDRESS_DETECT_ENABLE = 5;
  localparam int STA_RECEIVER_IDLE = 4;
  localparam int STA_PARITY_ERROR = 3;
  localparam int STA_FRAMING_ERROR = 2;
  localparam int STA_OVERRUN_ERROR = 1;
  localparam int STA_RDA = 0;

  localparam logic [15:0] MODE_WMASK = 16'hBBFF;
  localparam logic [15:0] STA_WMASK = 16'hECE0;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] STA_RESET = 16'h0000;
  localparam logic [15:0] RATE_RESET = 16'h0000;

  // oversampling ticks: last tick of a bit, mid-bit tick, infrared pulse and stretch; break length and auto rate edges
  localparam logic [3:0] LAST_TICK_STD = 4'hF;
  localparam logic [3:0] LAST_TICK_HS = 4'h3;
  localparam logic [3:0] HALF_TICK_STD = 4'h7;
  localparam logic [3:0] HALF_TICK_HS = 4'h1;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [4:0] IR_STRETCH = 5'h10;
  localparam logic [3:0] BREAK_LEN = 4'hE;
  localparam logic [2:0] AUTO_EDGES = 3'h4;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_e;

  typedef enum logic [1:0] {
    PIN_TXRX = 2'b00,
    PIN_RTS = 2'b01,
    PIN_FLOW = 2'b10,
    PIN_BAUDCLK = 2'b11
  } pin_usage_e;

  typedef enum logic [1:0] {
    FRAME_8N = 2'b00,
    FRAME_8E = 2'b01,
    FRAME_8O = 2'b10,
    FRAME_9N = 2'b11
  } frame_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic framing_error;
    logic parity_error;
    logic [8:0] data;
  } rx_char_s;

  typedef struct packed {
    logic idle;
    logic sleep;
  } power_mode_s;

endpackage

// ==== uart_infrared_control.sv ====
// serial transceiver with infrared codec, flow control and auto rate
//
// Behaviour
// - pin usage 11 with module enabled drives baud clock pin at tick rate, 16x, or 4x in high speed
// - infrared bit routes pins through pulse encoder/decoder, 16x mode only
// - module enable gives pins to the block; clear leaves pins, block idle
// - idle-stop set halts the block while the device idles
// - request mode bit: set simplex, clear flow control on request pin
// - pin usage selects which of tx, rx, cts, rts, baud clock are used
// - wake enable samples rx in sleep, fires on fall, clears on rise
// - auto rate measures a 55h sync byte then clears its enable
// - receive invert set makes rx idle low, else idle high
// - high speed bit gives 4 ticks per bit, else 16
// - frame field: 9 bit none, 8 odd, 8 even, 8 none
// - stop select set sends two stop bits, else one
// - tx interrupt: leaving buffer empty, all shifted out, or every load
// - encoded tx idle level follows polarity bit only in infrared mode
// - break request sends start, twelve zeros, stop, then self clears
// - clearing tx enable aborts, empties tx buffer, releases tx pin
// - tx full when buffer full; shifter empty when shifter and buffer empty
// - rx interrupt on buffer reaching four, three, or every character
// - address detect with 9 bit frames keeps only ninth-bit-set chars
// - parity and framing flags belong to the character at fifo head
// - overflow sets overrun; clearing it empties buffer and shifter
// - receiver idle while no character arrives; available when buffer holds
// - baud timer free runs with divisor period, cleared on divisor write
// - reading receive data pops head, exposing next character's flags
`timescale 1ns/10ps
module uart_infrared_control #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire uart_infrared_pkg::reg_req_s regReq,
  output logic [15:0] regRdata_q,
  input wire uart_infrared_pkg::power_mode_s powerMode,
  input wire logic serialInPin,
  input wire logic clearToSendPinN,
  output logic serialOutPin_q,
  output logic serialOutEn_q,
  output logic requestToSendPinN_q,
  output logic requestToSendEn_q,
  output logic baudClockPin_q,
  output logic baudClockEn_q,
  output logic txIrq_q,
  output logic rxIrq_q,
  output logic errIrq_q,
  output logic wakeIrq_q
);
  import uart_infrared_pkg::*;

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(FIFO_DEPTH);
  localparam logic [PTR_W:0] NEAR_C = (PTR_W+1)'(FIFO_DEPTH - 1);
  localparam logic [PTR_W:0] ONE_C = (PTR_W+1)'(1);

  if ((FIFO_DEPTH < 4) || ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)) begin
    $error("FIFO_DEPTH must be a power of two of at least 4");
  end

  logic [15:0] mode_q, ctrl_q, rateDiv_q, baudCnt_q;
  logic wrMode, wrCtrl, wrTx, wrRate, rdRx;

  always_comb begin
    wrMode = 1'b0;
    wrCtrl = 1'b0;
    wrTx = 1'b0;
    wrRate = 1'b0;
    rdRx = 1'b0;
    if (regReq.addr == MODE_OFFSET) begin
      wrMode = regReq.wr;
    end else if (regReq.addr == STATUS_OFFSET) begin
      wrCtrl = regReq.wr;
    end else if (regReq.addr == TXDATA_OFFSET) begin
      wrTx = regReq.wr;
    end else if (regReq.addr == RXDATA_OFFSET) begin
      rdRx = regReq.rd;
    end else if (regReq.addr == RATE_OFFSET) begin
      wrRate = regReq.wr;
    end
  end

  logic modEn, run, hs, irOn, nineBit, parOn, oddPar, txEn, txPol;
  pin_usage_e pinUse;
  frame_e frame;
  logic [3:0] lastTick, halfTick;
  logic [1:0] txIrqMode, rxIrqMode;

  assign modEn = mode_q[MODE_EN];
  assign run = modEn && !(mode_q[MODE_IDLE_STOP] && powerMode.idle)
               && !powerMode.sleep;
  assign hs = mode_q[MODE_HS];
  assign irOn = mode_q[MODE_IR] && !hs;
  assign pinUse = pin_usage_e'(mode_q[MODE_PIN_LO +: 2]);
  assign frame = frame_e'(mode_q[MODE_FRAME_LO +: 2]);
  assign nineBit = frame == FRAME_9N;
  assign parOn = (frame == FRAME_8E) || (frame == FRAME_8O);
  assign oddPar = frame == FRAME_8O;
  assign lastTick = hs ? LAST_TICK_HS : LAST_TICK_STD;
  assign halfTick = hs ? HALF_TICK_HS : HALF_TICK_STD;
  assign txEn = ctrl_q[STA_TX_EN];
  assign txPol = ctrl_q[STA_TX_POL];
  assign txIrqMode = {ctrl_q[STA_TXI1], ctrl_q[STA_TXI0]};
  assign rxIrqMode = ctrl_q[STA_RXI_LO +: 2];

  // baud timer
  logic tick;
  logic [15:0] halfDiv;
  assign tick = run && !wrRate && (baudCnt_q >= rateDiv_q);
  assign halfDiv = 16'((17'(rateDiv_q) + 17'h0_0001) >> 1);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      baudCnt_q <= 16'h0000;
    end else if (wrRate || !run || baudCnt_q >= rateDiv_q) begin
      baudCnt_q <= 16'h0000;
    end else begin
      baudCnt_q <= baudCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      baudClockPin_q <= 1'b0;
      baudClockEn_q <= 1'b0;
    end else begin
      baudClockEn_q <= modEn && pinUse == PIN_BAUDCLK;
      if (!run) begin
        baudClockPin_q <= 1'b0;
      end else if (baudCnt_q == 16'h0000) begin
        baudClockPin_q <= 1'b1;
      end else if (baudCnt_q == halfDiv) begin
        baudClockPin_q <= 1'b0;
      end
    end
  end

  // transmit buffer
  logic [8:0] txMem [FIFO_DEPTH];
  logic [PTR_W-1:0] txWrPtr_q, txRdPtr_q;
  logic [PTR_W:0] txCount_q;
  logic txPush, txLoad, txFlush, txDone, ctsOk;
  logic txBusy_q, txBreak_q;
  logic [13:0] txShift_q, txFrame;
  logic [3:0] txBitsLeft_q, txTick_q, txLen;
  logic [8:0] txHead;
  logic txPar, txLine, txEncoded;

  assign txPush = wrTx && txCount_q != DEPTH_C;
  assign txFlush = wrCtrl && txEn && !regReq.wdata[STA_TX_EN];
  assign ctsOk = pinUse != PIN_FLOW || !clearToSendPinN;
  assign txLoad = run && txEn && !txBusy_q && txCount_q != '0 && ctsOk;
  assign txDone = txBusy_q && tick && txTick_q == lastTick
                  && txBitsLeft_q == 4'h1;
  assign txHead = txMem[txRdPtr_q];
  assign txPar = (^txHead[7:0]) ^ oddPar;

  always_comb begin
    txLen = mode_q[MODE_STOP] ? 4'hB : 4'hA;
    txFrame = {5'b1_1111, txHead[7:0], 1'b0};
    if (ctrl_q[STA_BRK]) begin
      txFrame = {1'b1, 12'h000, 1'b0};
      txLen = BREAK_LEN;
    end else if (nineBit) begin
      txFrame = {4'b1111, txHead, 1'b0};
      txLen = txLen + 4'h1;
    end else if (parOn) begin
      txFrame = {4'b1111, txPar, txHead[7:0], 1'b0};
      txLen = txLen + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (txPush) begin
      txMem[txWrPtr_q] <= regReq.wdata[8:0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txWrPtr_q <= '0;
      txRdPtr_q <= '0;
      txCount_q <= '0;
    end else if (txFlush) begin
      txWrPtr_q <= '0;
      txRdPtr_q <= '0;
      txCount_q <= '0;
    end else begin
      if (txPush) begin
        txWrPtr_q <= txWrPtr_q + 1'b1;
      end
      if (txLoad) begin
        txRdPtr_q <= txRdPtr_q + 1'b1;
      end
      txCount_q <= txCount_q + (PTR_W+1)'(txPush) - (PTR_W+1)'(txLoad);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txBusy_q <= 1'b0;
      txBreak_q <= 1'b0;
      txShift_q <= 14'h3FFF;
      txBitsLeft_q <= 4'h0;
      txTick_q <= 4'h0;
    end else if (txFlush) begin
      txBusy_q <= 1'b0;
      txShift_q <= 14'h3FFF;
    end else if (txLoad) begin
      txBusy_q <= 1'b1;
      txBreak_q <= ctrl_q[STA_BRK];
      txShift_q <= txFrame;
      txBitsLeft_q <= txLen;
      txTick_q <= 4'h0;
    end else if (txBusy_q && tick) begin
      if (txTick_q == lastTick) begin
        txTick_q <= 4'h0;
        txShift_q <= {1'b1, txShift_q[13:1]};
        txBitsLeft_q <= txBitsLeft_q - 4'h1;
        txBusy_q <= txBitsLeft_q != 4'h1;
      end else begin
        txTick_q <= txTick_q + 4'h1;
      end
    end
  end

  assign txLine = txBusy_q ? txShift_q[0] : 1'b1;
  // zero bits become a short pulse away from the idle level
  assign txEncoded = irOn ? ((!txLine && txTick_q < IR_PULSE_TICKS) ?
                     !txPol : txPol) : txLine;

  // receive path
  logic rxLevel, rxBit, rxPrev_q, rxFall, rxRise;
  logic [4:0] irStretch_q;
  assign rxLevel = (mode_q[MODE_LOOP] ? txEncoded : serialInPin)
                   ^ mode_q[MODE_RX_INV];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irStretch_q <= 5'h00;
    end else if (!irOn) begin
      irStretch_q <= 5'h00;
    end else if (!rxLevel) begin
      irStretch_q <= IR_STRETCH;
    end else if (tick && irStretch_q != 5'h00) begin
      irStretch_q <= irStretch_q - 5'h01;
    end
  end

  assign rxBit = irOn ? (rxLevel && irStretch_q == 5'h00) : rxLevel;
  assign rxFall = rxPrev_q && !rxBit;
  assign rxRise = !rxPrev_q && rxBit;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxPrev_q <= 1'b1;
    end else begin
      rxPrev_q <= rxBit;
    end
  end

  // auto rate: start edge plus four falls of 55h span eight bit times
  logic abActive_q, abDone;
  logic [2:0] abEdges_q;
  logic [22:0] abCnt_q;
  logic [15:0] abBits;
  assign abDone = abActive_q && rxFall && abEdges_q == AUTO_EDGES - 3'h1;
  assign abBits = hs ? abCnt_q[20:5] : abCnt_q[22:7];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      abActive_q <= 1'b0;
      abEdges_q <= 3'h0;
      abCnt_q <= 23'h00_0000;
    end else if (!mode_q[MODE_AUTO] || !run || abDone) begin
      abActive_q <= 1'b0;
    end else if (!abActive_q) begin
      abActive_q <= rxFall;
      abEdges_q <= 3'h0;
      abCnt_q <= 23'h00_0001;
    end else begin
      abCnt_q <= abCnt_q + 23'h00_0001;
      if (rxFall) begin
        abEdges_q <= abEdges_q + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rateDiv_q <= RATE_RESET;
    end else if (wrRate) begin
      rateDiv_q <= regReq.wdata;
    end else if (abDone) begin
      rateDiv_q <= (abBits == 16'h0000) ? 16'h0000 : abBits - 16'h0001;
    end
  end

  // receive state machine
  rx_state_e rxState_q;
  logic [3:0] rxTick_q, rxIdx_q, rxLastIdx;
  logic [9:0] rxShift_q;
  logic rxFlush, rxStopDone, rxPush, rxOverflow, overrun_q;
  rx_char_s rxChar, rxHead;
  rx_char_s rxMem [FIFO_DEPTH];
  logic [PTR_W-1:0] rxWrPtr_q, rxRdPtr_q;
  logic [PTR_W:0] rxCount_q;
  logic rxPop;

  assign rxLastIdx = (nineBit || parOn) ? 4'h8 : 4'h7;
  assign rxFlush = wrCtrl && overrun_q && !regReq.wdata[STA_OVERRUN_ERROR];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxState_q <= RX_IDLE;
      rxTick_q <= 4'h0;
      rxIdx_q <= 4'h0;
      rxShift_q <= 10'h000;
    end else if (rxFlush || !run) begin
      rxState_q <= RX_IDLE;
    end else begin
      case (rxState_q)
        RX_IDLE: begin
          if (rxFall && !mode_q[MODE_AUTO]) begin
            rxState_q <= RX_START;
            rxTick_q <= 4'h0;
          end
        end
        RX_START: begin
          if (tick && rxTick_q == halfTick) begin
            rxState_q <= rxBit ? RX_IDLE : RX_DATA;
            rxTick_q <= 4'h0;
            rxIdx_q <= 4'h0;
          end else if (tick) begin
            rxTick_q <= rxTick_q + 4'h1;
          end
        end
        RX_DATA: begin
          if (tick && rxTick_q == lastTick) begin
            rxTick_q <= 4'h0;
            rxShift_q <= {rxBit, rxShift_q[9:1]};
            rxIdx_q <= rxIdx_q + 4'h1;
            if (rxIdx_q == rxLastIdx) begin
              rxState_q <= RX_STOP;
            end
          end else if (tick) begin
            rxTick_q <= rxTick_q + 4'h1;
          end
        end
        RX_STOP: begin
          if (tick && rxTick_q == lastTick) begin
            rxState_q <= RX_IDLE;
          end else if (tick) begin
            rxTick_q <= rxTick_q + 4'h1;
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  assign rxStopDone = run && !rxFlush && rxState_q == RX_STOP && tick
                      && rxTick_q == lastTick;

  always_comb begin
    rxChar.data = nineBit ? rxShift_q[9:1] :
                  {1'b0, parOn ? rxShift_q[8:1] : rxShift_q[9:2]};
    rxChar.parity_error = parOn && ((^rxShift_q[9:1]) != oddPar);
    rxChar.framing_error = !rxBit;
  end

  assign rxPush = rxStopDone && rxCount_q != DEPTH_C
                  && !(ctrl_q[STA_ADDRESS_DETECT_ENABLE] && nineBit && !rxChar.data[8]);
  assign rxOverflow = rxStopDone && rxCount_q == DEPTH_C;
  assign rxPop = rdRx && rxCount_q != '0;
  assign rxHead = rxMem[rxRdPtr_q];

  always_ff @(posedge ref_clk) begin
    if (rxPush) begin
      rxMem[rxWrPtr_q] <= rxChar;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxWrPtr_q <= '0;
      rxRdPtr_q <= '0;
      rxCount_q <= '0;
    end else if (rxFlush) begin
      rxWrPtr_q <= '0;
      rxRdPtr_q <= '0;
      rxCount_q <= '0;
    end else begin
      if (rxPush) begin
        rxWrPtr_q <= rxWrPtr_q + 1'b1;
      end
      if (rxPop) begin
        rxRdPtr_q <= rxRdPtr_q + 1'b1;
      end
      rxCount_q <= rxCount_q + (PTR_W+1)'(rxPush) - (PTR_W+1)'(rxPop);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      overrun_q <= 1'b0;
    end else if (rxOverflow) begin
      overrun_q <= 1'b1;
    end else if (rxFlush) begin
      overrun_q <= 1'b0;
    end
  end

  // wake from sleep on a falling receive line
  logic wakeSeen_q, wakeClr;
  assign wakeClr = wakeSeen_q && rxRise;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wakeSeen_q <= 1'b0;
    end else if (!mode_q[MODE_WAKE] || wakeClr) begin
      wakeSeen_q <= 1'b0;
    end else if (powerMode.sleep && rxFall) begin
      wakeSeen_q <= 1'b1;
    end
  end

  // control registers; software writes win over hardware clears
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_q <= MODE_RESET;
    end else if (wrMode) begin
      mode_q <= regReq.wdata & MODE_WMASK;
    end else begin
      if (abDone) begin
        mode_q[MODE_AUTO] <= 1'b0;
      end
      if (wakeClr) begin
        mode_q[MODE_WAKE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= STA_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= regReq.wdata & STA_WMASK;
    end else if (txDone && txBreak_q) begin
      ctrl_q[STA_BRK] <= 1'b0;
    end
  end

  // status and read data
  logic [15:0] status;
  logic txFull, shifterEmpty, haveRx;
  assign txFull = txCount_q == DEPTH_C;
  assign shifterEmpty = !txBusy_q && txCount_q == '0;
  assign haveRx = rxCount_q != '0;

  always_comb begin
    status = ctrl_q;
    status[STA_FULL] = txFull;
    status[STA_EMPTY] = shifterEmpty;
    status[STA_RECEIVER_IDLE] = rxState_q == RX_IDLE;
    status[STA_PARITY_ERROR] = haveRx && rxHead.parity_error;
    status[STA_FRAMING_ERROR] = haveRx && rxHead.framing_error;
    status[STA_OVERRUN_ERROR] = overrun_q;
    status[STA_RDA] = haveRx;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regRdata_q <= 16'h0000;
    end else if (!regReq.rd) begin
      regRdata_q <= 16'h0000;
    end else if (regReq.addr == MODE_OFFSET) begin
      regRdata_q <= mode_q;
    end else if (regReq.addr == STATUS_OFFSET) begin
      regRdata_q <= status;
    end else if (regReq.addr == RXDATA_OFFSET) begin
      regRdata_q <= haveRx ? {7'h00, rxHead.data} : 16'h0000;
    end else if (regReq.addr == RATE_OFFSET) begin
      regRdata_q <= rateDiv_q;
    end else begin
      regRdata_q <= 16'h0000;
    end
  end

  // pins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      serialOutPin_q <= 1'b1;
      serialOutEn_q <= 1'b0;
      requestToSendPinN_q <= 1'b1;
      requestToSendEn_q <= 1'b0;
    end else begin
      serialOutEn_q <= modEn && txEn;
      serialOutPin_q <= txEncoded;
      requestToSendEn_q <= modEn
                           && (pinUse == PIN_RTS || pinUse == PIN_FLOW);
      if (mode_q[MODE_RTS_MODE]) begin
        requestToSendPinN_q <= shifterEmpty;
      end else begin
        requestToSendPinN_q <= rxCount_q == DEPTH_C;
      end
    end
  end

  // interrupt request pulses
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txIrq_q <= 1'b0;
      rxIrq_q <= 1'b0;
      errIrq_q <= 1'b0;
      wakeIrq_q <= 1'b0;
    end else begin
      case (txIrqMode)
        2'b10: txIrq_q <= txLoad && txCount_q == ONE_C && !txPush;
        2'b01: txIrq_q <= txDone && txCount_q == '0;
        2'b00: txIrq_q <= txLoad;
        default: txIrq_q <= 1'b0;
      endcase
      case (rxIrqMode)
        2'b11: rxIrq_q <= rxPush && rxCount_q == NEAR_C;
        2'b10: rxIrq_q <= rxPush && rxCount_q == NEAR_C - ONE_C;
        default: rxIrq_q <= rxPush;
      endcase
      errIrq_q <= rxOverflow
                  || (rxPush && (rxChar.parity_error || rxChar.framing_error));
      wakeIrq_q <= mode_q[MODE_WAKE] && !wakeSeen_q
                   && powerMode.sleep && rxFall;
    end
  end

endmodule

// ==== uart_infrared_control_properties.sv ====
// port assertions for the serial controller, with its bind
`timescale 1ns/10ps
module uart_infrared_control_properties (
  input wire logic ref_clk,
  input wire logic reset,
  input wire uart_infrared_pkg::reg_req_s regReq,
  input wire logic [15:0] regRdata_q,
  input wire logic serialOutEn_q,
  input wire logic requestToSendEn_q,
  input wire logic baudClockEn_q,
  input wire logic txIrq_q,
  input wire logic rxIrq_q,
  input wire logic errIrq_q
);
  import uart_infrared_pkg::*;
  logic [15:0] modeQ;
  logic [15:0] staQ;
  logic [1:0] quietQ;
  logic quiet;
  logic on;
  assign quiet = quietQ == 2'h3;
  assign on = modeQ[MODE_EN];
  // software view of the control registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      modeQ <= MODE_RESET;
      staQ <= STA_RESET;
    end else if (regReq.wr && regReq.addr == MODE_OFFSET) begin
      modeQ <= regReq.wdata & MODE_WMASK;
    end else if (regReq.wr && regReq.addr == STATUS_OFFSET) begin
      staQ <= regReq.wdata & STA_WMASK;
    end
  end
  // settles three cycles after the last write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      quietQ <= 2'h0;
    end else begin
      quietQ <= regReq.wr ? 2'h0 : (quiet ? quietQ : quietQ + 2'h1);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_BAUD_CLOCK_OWNER: assert property (
    quiet |-> baudClockEn_q == (on && modeQ[9:8] == 2'h3))
    else $error("baud clock enable wrong");
  AST_RTS_OWNER: assert property (
    quiet |-> requestToSendEn_q ==
      (on && (modeQ[9:8] == 2'h1 || modeQ[9:8] == 2'h2)))
    else $error("rts enable wrong");
  AST_TX_PIN_OWNER: assert property (
    quiet |-> serialOutEn_q == (on && staQ[STA_TX_EN]))
    else $error("tx pin enable wrong");
  AST_DISABLED_RELEASES: assert property (
    quiet && !on |-> !serialOutEn_q && !baudClockEn_q && !requestToSendEn_q)
    else $error("disabled block holds a pin");
  AST_MODE_READBACK: assert property (
    regReq.rd && regReq.addr == MODE_OFFSET |=>
      ((regRdata_q ^ $past(modeQ)) & 16'hFF5F) == 16'h0000)
    else $error("mode readback wrong");
  AST_TXIRQ_PULSE: assert property (
    txIrq_q |=> !txIrq_q)
    else $error("tx irq longer than one cycle");
  AST_TXIRQ_RESERVED: assert property (
    quiet && staQ[STA_TXI1] && staQ[STA_TXI0] |-> !txIrq_q)
    else $error("tx irq in reserved mode");
  AST_RXIRQ_SPACED: assert property (
    rxIrq_q |=> !rxIrq_q [*8])
    else $error("rx irq repeats too soon");
  AST_ERRIRQ_PULSE: assert property (
    errIrq_q |=> !errIrq_q)
    else $error("error irq longer than one cycle");
endmodule
bind uart_infrared_control uart_infrared_control_properties
  uart_infrared_control_properties_i (.ref_clk, .reset, .regReq,
  .regRdata_q, .serialOutEn_q, .requestToSendEn_q, .baudClockEn_q,
  .txIrq_q, .rxIrq_q, .errIrq_q);

// ==== remote_serial_model.sv ====
// remote serial partner: sends and receives 8N1 frames
`timescale 1ns/10ps
module remote_serial_model #(
  parameter int BIT = 16
) (
  input wire logic ref_clk,
  input wire logic serialOutPin,
  output logic serialLine,
  output logic [7:0] rxByte,
  output logic rxDone
);
  initial begin
    serialLine = 1'b1;
    rxByte = 8'h00;
    rxDone = 1'b0;
  end
  // start, data lsb first, one stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serialLine <= f[i];
      repeat (BIT) @(posedge ref_clk);
    end
  endtask
  // mid-bit sampling of the block's line
  always begin
    @(posedge ref_clk);
    if (serialOutPin === 1'b0) begin
      repeat (BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge ref_clk);
        rxByte[i] <= serialOutPin;
      end
      repeat (BIT) @(posedge ref_clk);
      rxDone <= 1'b1;
      @(posedge ref_clk);
      rxDone <= 1'b0;
    end
  end
endmodule

// ==== uart_infrared_control_tb.sv ====
// self-checking bench for the serial controller
`timescale 1ns/10ps
module uart_infrared_control_tb;
  import uart_infrared_pkg::*;
  logic ref_clk, reset, serialLine, rxDone, rdSeen, outPin, outEn, lineOut;
  logic wakeP;
  power_mode_s pm;
  logic [15:0] regRdata_q;
  logic [15:0] eq[$];
  logic [7:0] rxByte, lfsr;
  logic [7:0] b[5];
  string nq[$];
  reg_req_s req;
  int n_errors, cmp_count;
  assign lineOut = outEn ? outPin : 1'b1;
  uart_infrared_control uart_infrared_control_i (.ref_clk, .reset,
    .regReq(req), .regRdata_q, .powerMode(pm), .serialInPin(serialLine),
    .clearToSendPinN(1'b1), .serialOutPin_q(outPin), .serialOutEn_q(outEn),
    .requestToSendPinN_q(), .requestToSendEn_q(), .baudClockPin_q(),
    .baudClockEn_q(), .txIrq_q(), .rxIrq_q(), .errIrq_q(), .wakeIrq_q(wakeP));
  remote_serial_model remote_serial_model_i (.ref_clk,
    .serialOutPin(lineOut), .serialLine, .rxByte, .rxDone);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic note(input logic [15:0] e, input string n);
    eq.push_back(e);
    nq.push_back(n);
  endtask
  task automatic access(input logic [7:0] a, input logic [15:0] d,
                        input logic w);
    req <= '{a, d, w, !w};
    tick(1);
    req <= '{a, d, 1'b0, 1'b0};
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input string n);
    note(e, n);
    access(a, 16'h0000, 1'b0);
  endtask
  task automatic drain;
    for (int i = 0; i < 400 && eq.size() > 0; i++) tick(1);
    if (eq.size() > 0) begin
      n_errors++;
      $display("wrong value wait expected %0d seen %0d", 0, eq.size());
      conclude();
    end
  endtask
  task automatic compare(input logic [15:0] v);
    logic [15:0] e;
    string n;
    e = eq.size() > 0 ? eq.pop_front() : 16'hxxxx;
    n = nq.size() > 0 ? nq.pop_front() : "extra";
    cmp_count++;
    if (v !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  always @(posedge ref_clk) begin
    rdSeen <= req.rd;
    if (rdSeen) compare(regRdata_q);
    if (rxDone) compare({8'h00, rxByte});
    if (wakeP) compare(16'h0001);
  end
  initial begin
    reset = 1'b1;
    req = '0;
    pm = '0;
    rdSeen = 1'b0;
    lfsr = 8'h47;
    n_errors = 0;
    cmp_count = 0;
    tick(20);
    reset <= 1'b0;
    tick(1);
    access(RATE_OFFSET, 16'h0000, 1'b1);
    access(MODE_OFFSET, 16'h8300, 1'b1);
    access(STATUS_OFFSET, 16'h0400, 1'b1);
    rd(MODE_OFFSET, 16'h8300, "mode");
    rd(8'h14, 16'h0000, "unmapped");
    tick(4);
    rd(STATUS_OFFSET, 16'h0510, "idle status");
    drain();
    $display("registers test done");
    for (int k = 0; k < 3; k++) begin
      lfsr = nextRand(lfsr);
      note({8'h00, lfsr}, "line byte");
      access(TXDATA_OFFSET, {8'h00, lfsr}, 1'b1);
      drain();
      remote_serial_model_i.send(lfsr);
      tick(4);
      rd(RXDATA_OFFSET, {8'h00, lfsr}, "rx data");
      drain();
    end
    $display("traffic test done");
    for (int k = 0; k < 5; k++) begin
      lfsr = nextRand(lfsr);
      b[k] = lfsr;
      remote_serial_model_i.send(lfsr);
    end
    tick(4);
    rd(STATUS_OFFSET, 16'h0513, "overrun status");
    rd(RXDATA_OFFSET, {8'h00, b[0]}, "fifo head");
    access(STATUS_OFFSET, 16'h0400, 1'b1);
    tick(4);
    rd(STATUS_OFFSET, 16'h0510, "flushed status");
    rd(RXDATA_OFFSET, 16'h0000, "empty read");
    drain();
    $display("overrun test done");
    access(MODE_OFFSET, 16'h8328, 1'b1);
    remote_serial_model_i.send(8'h55);
    tick(4);
    rd(RATE_OFFSET, 16'h0003, "auto rate");
    rd(MODE_OFFSET, 16'h8308, "auto cleared");
    note({8'h00, b[3]}, "fast byte");
    access(TXDATA_OFFSET, {8'h00, b[3]}, 1'b1);
    drain();
    $display("auto rate test done");
    pm <= '{1'b0, 1'b1};
    access(MODE_OFFSET, 16'h8388, 1'b1);
    note(16'h0001, "wake irq");
    remote_serial_model_i.send(b[2]);
    tick(4);
    rd(MODE_OFFSET, 16'h8308, "wake cleared");
    pm <= '0;
    drain();
    $display("wake test done");
    access(STATUS_OFFSET, 16'hA400, 1'b1);
    tick(4);
    note({8'h00, b[4]}, "reserved irq byte");
    access(TXDATA_OFFSET, {8'h00, b[4]}, 1'b1);
    drain();
    access(MODE_OFFSET, 16'h0000, 1'b1);
    tick(4);
    rd(MODE_OFFSET, 16'h0000, "mode off");
    drain();
    $display("reserved and disable test done");
    conclude();
  end
endmodule
